/* File: design/crf_pkg.sv */
// Package of constants and carrier types for the processor register file
package crf_pkg;
	// ============================================================
	// Widths and counts
	localparam int unsigned CRF_DATA_W    = 32;
	localparam int unsigned CRF_NUM_REGS  = 32;
	localparam int unsigned CRF_IDX_W     = 5;
	localparam int unsigned CRF_SPR_W     = 3;

	// ============================================================
	// Fixed general register indices: hardwired zero and those written by hardware
	localparam logic [4:0] CRF_IDX_ZERO  = 5'h00;
	localparam logic [4:0] CRF_IDX_INTR  = 5'h0E;
	localparam logic [4:0] CRF_IDX_LINK  = 5'h0F;
	localparam logic [4:0] CRF_IDX_TRAP  = 5'h10;
	localparam logic [4:0] CRF_IDX_EXCP  = 5'h11;

	// ============================================================
	// Special register selectors (separate space from general file)
	localparam logic [2:0] CRF_SPR_PC   = 3'h0;
	localparam logic [2:0] CRF_SPR_MSR  = 3'h1;
	localparam logic [2:0] CRF_SPR_EAR  = 3'h3;
	localparam logic [2:0] CRF_SPR_ESR  = 3'h5;
	localparam logic [2:0] CRF_SPR_FSR  = 3'h7;

	// ============================================================
	// Reset values
	localparam logic [31:0] CRF_RST_WORD = 32'h0000_0000;

	// ============================================================
	// Write port priority select (one-hot)
	typedef enum logic [4:0] {
		CRF_WS_NONE = 5'h00,
		CRF_WS_EXCP = 5'h01,
		CRF_WS_INTR = 5'h02,
		CRF_WS_TRAP = 5'h04,
		CRF_WS_LINK = 5'h08,
		CRF_WS_OPND = 5'h10
	} crf_wsel_t;

	// Ordinary operand write request
	typedef struct packed {
		logic        en;
		logic [4:0]  idx;
		logic [31:0] data;
	} crf_wreq_t;

	// Special register transfer request
	typedef struct packed {
		logic        en;
		logic [2:0]  sel;
		logic [31:0] data;
	} crf_sreq_t;
endpackage

/* File: design/crf_spr_bank.sv */
// Special register bank kept apart from the general file
`timescale 1ns/10ps
`default_nettype none
module crf_spr_bank
	import crf_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	// Move-to-special write
	input  var  crf_sreq_t   mts_req,
	// Hardware updates
	input  wire logic [31:0] pc_in,
	input  wire logic        hw_upd,
	input  wire logic [31:0] msr_hw,
	input  wire logic [31:0] ear_hw,
	input  wire logic [31:0] esr_hw,
	input  wire logic [31:0] fsr_hw,
	// Read port
	input  wire logic [2:0]  rd_sel,
	output logic [31:0]      rd_data,
	output logic             rd_valid
);
	// ============================================================
	// Storage
	logic [31:0] msr_reg, ear_reg, esr_reg, fsr_reg;

	// Hardware update wins over software write in the same cycle
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			msr_reg <= CRF_RST_WORD;
			ear_reg <= CRF_RST_WORD;
			esr_reg <= CRF_RST_WORD;
			fsr_reg <= CRF_RST_WORD;
		end else if (hw_upd) begin
			msr_reg <= msr_hw;
			ear_reg <= ear_hw;
			esr_reg <= esr_hw;
			fsr_reg <= fsr_hw;
		end else if (mts_req.en) begin
			if (mts_req.sel == CRF_SPR_MSR) msr_reg <= mts_req.data;
			if (mts_req.sel == CRF_SPR_EAR) ear_reg <= mts_req.data;
			if (mts_req.sel == CRF_SPR_ESR) esr_reg <= mts_req.data;
			if (mts_req.sel == CRF_SPR_FSR) fsr_reg <= mts_req.data;
		end
	end

	// Move-to lands unless hardware updates in the same cycle
	a_mts_load: assert property (@(posedge sys_clk)
		disable iff (!rstn)
		(mts_req.en && !hw_upd && mts_req.sel == CRF_SPR_ESR)
		|=> (esr_reg == $past(mts_req.data)))
		else $error("move-to-special value not loaded");
	a_hw_load: assert property (@(posedge sys_clk)
		disable iff (!rstn)
		hw_upd |=> (msr_reg == $past(msr_hw) && fsr_reg == $past(fsr_hw)))
		else $error("hardware status update not loaded");

	// Read selection; program counter comes straight from the pipeline
	assign rd_valid = (rd_sel == CRF_SPR_PC) || (rd_sel == CRF_SPR_MSR) ||
		(rd_sel == CRF_SPR_EAR) || (rd_sel == CRF_SPR_ESR) ||
		(rd_sel == CRF_SPR_FSR);
	assign rd_data = (rd_sel == CRF_SPR_PC)  ? pc_in   :
		(rd_sel == CRF_SPR_MSR) ? msr_reg :
		(rd_sel == CRF_SPR_EAR) ? ear_reg :
		(rd_sel == CRF_SPR_ESR) ? esr_reg :
		(rd_sel == CRF_SPR_FSR) ? fsr_reg : CRF_RST_WORD;
endmodule // crf_spr_bank
`default_nettype wire

/* File: design/crf_regfile.sv */
// General register file with hardware return-address writes
`timescale 1ns/10ps
`default_nettype none
module crf_regfile
	import crf_pkg::*;
#(
	parameter int unsigned NUM_REGS   = CRF_NUM_REGS,
	parameter int unsigned DATA_W     = CRF_DATA_W,
	parameter bit          USE_HW_EXC = 1'b0
) (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	// Operand read ports
	input  wire logic [4:0]  rd_a_idx,
	input  wire logic [4:0]  rd_b_idx,
	input  wire logic [4:0]  rd_d_idx,
	output logic [31:0]      rd_a_data,
	output logic [31:0]      rd_b_data,
	output logic [31:0]      rd_d_data,
	// Operand write port
	input  var  crf_wreq_t   wr_req,
	// Hardware events
	input  wire logic [31:0] pc_in,
	input  wire logic [31:0] ret_addr,
	input  wire logic        intr_take,
	input  wire logic        trap_take,
	input  wire logic        excp_take,
	input  wire logic        link_take,
	// Special register transfers
	input  wire logic        mfs_en,
	input  wire logic [2:0]  mfs_sel,
	input  wire logic [4:0]  mfs_dst,
	input  wire logic        mts_en,
	input  wire logic [2:0]  mts_sel,
	input  wire logic [4:0]  mts_src,
	input  wire logic        spr_hw_upd,
	input  wire logic [31:0] msr_hw,
	input  wire logic [31:0] ear_hw,
	input  wire logic [31:0] esr_hw,
	input  wire logic [31:0] fsr_hw,
	output logic [31:0]      spr_rd_data,
	output logic             spr_rd_valid
);
	// ============================================================
	// Elaboration checks
	if (NUM_REGS != 32 || DATA_W != 32) begin : g_bad_cfg
		$error("crf_regfile supports only 32 registers of 32 bits");
	end

	// ============================================================
	// Storage and declarations
	logic [31:0] gpr_reg [NUM_REGS];
	logic [31:0] spr_val;
	logic        spr_ok;
	crf_sreq_t   mts_req;
	crf_wsel_t   wsel;
	logic [4:0]  w_idx;
	logic [31:0] w_data;
	logic        w_en;
	wire         excp_ok = excp_take && USE_HW_EXC;

	// Read helper with zero register forced
	function automatic logic [31:0] rd_d_data_f(input logic [4:0] i);
		rd_d_data_f = (i == CRF_IDX_ZERO) ? CRF_RST_WORD : gpr_reg[i];
	endfunction

	// Special bank, fed from the general file for move-to
	crf_spr_bank u_spr (
		.sys_clk  (sys_clk),
		.rstn     (rstn),
		.mts_req  (mts_req),
		.pc_in    (pc_in),
		.hw_upd   (spr_hw_upd),
		.msr_hw   (msr_hw),
		.ear_hw   (ear_hw),
		.esr_hw   (esr_hw),
		.fsr_hw   (fsr_hw),
		.rd_sel   (mfs_sel),
		.rd_data  (spr_val),
		.rd_valid (spr_ok)
	);
	assign mts_req.en   = mts_en;
	assign mts_req.sel  = mts_sel;
	assign mts_req.data = rd_d_data_f(mts_src);
	assign spr_rd_data  = spr_val;
	assign spr_rd_valid = spr_ok;

	// Operand reads: only general indices reach the file
	assign rd_a_data = rd_d_data_f(rd_a_idx);
	assign rd_b_data = rd_d_data_f(rd_b_idx);
	assign rd_d_data = rd_d_data_f(rd_d_idx);

	// Single write port; exception over interrupt over trap over link
	assign wsel = excp_ok   ? CRF_WS_EXCP :
		intr_take ? CRF_WS_INTR :
		trap_take ? CRF_WS_TRAP :
		link_take ? CRF_WS_LINK :
		(wr_req.en || (mfs_en && spr_ok)) ? CRF_WS_OPND : CRF_WS_NONE;

	// Write target and data decode
	always_comb begin
		w_idx  = CRF_IDX_ZERO;
		w_data = ret_addr;
		unique case (wsel)
			CRF_WS_EXCP: w_idx = CRF_IDX_EXCP;
			CRF_WS_INTR: w_idx = CRF_IDX_INTR;
			CRF_WS_TRAP: w_idx = CRF_IDX_TRAP;
			CRF_WS_LINK: begin
				w_idx  = CRF_IDX_LINK;
				w_data = pc_in;
			end
			CRF_WS_OPND: begin
				w_idx  = mfs_en ? mfs_dst : wr_req.idx;
				w_data = mfs_en ? spr_val : wr_req.data;
			end
			CRF_WS_NONE: w_idx = CRF_IDX_ZERO;
			default:     w_idx = CRF_IDX_ZERO;
		endcase
	end
	assign w_en = (wsel != CRF_WS_NONE) && (w_idx != CRF_IDX_ZERO);

	// Register array, one flop row per entry
	for (genvar g = 0; g < 32; g++) begin : g_gpr
		always_ff @(posedge sys_clk or negedge rstn) begin
			if (!rstn)
				gpr_reg[g] <= CRF_RST_WORD;
			else if (w_en && (w_idx == 5'(g)))
				gpr_reg[g] <= w_data;
		end
	end

	// ============================================================
	// Assertions
	// Register zero on every read port and in storage
	a_zero_reads: assert property (@(posedge sys_clk)
		disable iff (!rstn)
		(rd_a_idx == CRF_IDX_ZERO) |-> (rd_a_data == 32'h0000_0000))
		else $error("register zero read nonzero");
	a_zero_rd_b: assert property (@(posedge sys_clk)
		disable iff (!rstn)
		(rd_b_idx == CRF_IDX_ZERO) |-> (rd_b_data == 32'h0000_0000))
		else $error("register zero read nonzero on port b");
	a_zero_rd_d: assert property (@(posedge sys_clk)
		disable iff (!rstn)
		(rd_d_idx == CRF_IDX_ZERO) |-> (rd_d_data == 32'h0000_0000))
		else $error("register zero read nonzero on port d");
	a_zero_store: assert property (@(posedge sys_clk)
		disable iff (!rstn)
		gpr_reg[0] == 32'h0000_0000)
		else $error("register zero storage changed");
	a_zero_nowr: assert property (@(posedge sys_clk)
		disable iff (!rstn)
		w_en |-> (w_idx != CRF_IDX_ZERO))
		else $error("write enabled toward register zero");

	// Return addresses land in their fixed registers; link saves pc_in into r15
	a_intr_ret: assert property (@(posedge sys_clk)
		disable iff (!rstn)
		(intr_take && !excp_ok) |=> (gpr_reg[14] == $past(ret_addr)))
		else $error("interrupt return address not in r14");
	a_trap_ret: assert property (@(posedge sys_clk)
		disable iff (!rstn)
		(trap_take && !intr_take && !excp_ok)
		|=> (gpr_reg[16] == $past(ret_addr)))
		else $error("trap return address not in r16");
	a_excp_ret: assert property (@(posedge sys_clk)
		disable iff (!rstn)
		excp_ok |=> (gpr_reg[17] == $past(ret_addr)))
		else $error("exception return address not in r17");
	a_excp_off: assert property (@(posedge sys_clk)
		disable iff (!rstn)
		(excp_take && !USE_HW_EXC && !intr_take && !trap_take && !link_take
		&& !wr_req.en && !mfs_en) |=> $stable(gpr_reg[17]))
		else $error("r17 written with exceptions disabled");
	a_link_pc: assert property (@(posedge sys_clk)
		disable iff (!rstn)
		(link_take && !intr_take && !trap_take && !excp_ok)
		|=> (gpr_reg[15] == $past(pc_in)))
		else $error("link did not save pc into r15");

	// One write source per cycle, in fixed priority
	a_one_src: assert property (@(posedge sys_clk)
		disable iff (!rstn)
		$onehot0(wsel))
		else $error("more than one write source selected");
	a_excp_wins: assert property (@(posedge sys_clk)
		disable iff (!rstn)
		excp_ok |-> (wsel == CRF_WS_EXCP))
		else $error("exception lost the write port");
	a_intr_wins: assert property (@(posedge sys_clk)
		disable iff (!rstn)
		(intr_take && !excp_ok) |-> (wsel == CRF_WS_INTR))
		else $error("interrupt lost the write port");
	a_link_wins: assert property (@(posedge sys_clk)
		disable iff (!rstn)
		(link_take && !intr_take && !trap_take && !excp_ok)
		|-> (wsel == CRF_WS_LINK))
		else $error("link lost the write port");

	// Special transfers and operand writes
	a_mfs_copy: assert property (@(posedge sys_clk)
		disable iff (!rstn)
		(mfs_en && spr_ok && mfs_dst != 5'h00 && !intr_take && !trap_take
		&& !excp_ok && !link_take)
		|=> (gpr_reg[$past(mfs_dst)] == $past(spr_val)))
		else $error("move-from-special copy lost");
	a_mfs_bad: assert property (@(posedge sys_clk)
		disable iff (!rstn)
		(mfs_en && !spr_ok && !wr_req.en && !intr_take && !trap_take
		&& !excp_ok && !link_take)
		|=> (gpr_reg[$past(mfs_dst)] == $past(gpr_reg[mfs_dst])))
		else $error("invalid special selector changed a register");
	a_opnd_write: assert property (@(posedge sys_clk)
		disable iff (!rstn)
		(wr_req.en && !mfs_en && wr_req.idx != 5'h00 && !intr_take
		&& !trap_take && !excp_ok && !link_take)
		|=> (gpr_reg[$past(wr_req.idx)] == $past(wr_req.data)))
		else $error("operand write lost");
	a_spr_valid: assert property (@(posedge sys_clk)
		disable iff (!rstn)
		(mfs_sel == CRF_SPR_PC) |-> (spr_rd_valid
		&& spr_rd_data == pc_in))
		else $error("pc not readable as special");
endmodule // crf_regfile
`default_nettype wire

/* File: tb/crf_pipe_model.sv */
// Pipeline stand-in: program counter, return address, event pulses
`timescale 1ns/10ps
`default_nettype none
module crf_pipe_model (
	// Clock
	input  wire logic        sys_clk,
	// Program flow
	output logic      [31:0] pc_in,
	output logic      [31:0] ret_addr,
	// Event pulses: excp, intr, trap, link
	output logic      [3:0]  ev
);
	// ============================================================
	// Fetch advances one word per cycle
	initial pc_in = 32'h0000_0100;
	initial ev = 4'h0;
	always @(posedge sys_clk) pc_in <= pc_in + 32'h4;
	// Return address lies past the current instruction
	assign ret_addr = pc_in + 32'h4;
	// Event request, held by the caller for one cycle
	task automatic set_ev(input logic [3:0] k);
		ev = k;
	endtask
endmodule // crf_pipe_model
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the general register file
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import crf_pkg::*;
;
	// ============================================================
	// Signals
	logic        sys_clk, rstn, mfs_en, mts_en, hw_upd, spr_rd_valid;
	logic [4:0]  rd_a_idx, rd_b_idx, rd_d_idx, mfs_dst, mts_src;
	logic [31:0] rd_a_data, rd_b_data, rd_d_data, spr_rd_data;
	logic [31:0] pc_in, ret_addr, hw_msr, hw_ear, hw_esr, hw_fsr, hx_a;
	logic [2:0]  mfs_sel, mts_sel;
	logic [3:0]  ev;
	crf_wreq_t   wr_req;
	int          errors, n_checks;
	logic [2:0]  sels [4] = '{CRF_SPR_MSR, CRF_SPR_EAR, CRF_SPR_ESR,
		CRF_SPR_FSR};
	// ============================================================
	// Design and pipeline stand-in
	crf_regfile #(.USE_HW_EXC(1'b0)) u_dut (.sys_clk(sys_clk),
		.rstn(rstn), .rd_a_idx(rd_a_idx), .rd_b_idx(rd_b_idx),
		.rd_d_idx(rd_d_idx), .rd_a_data(rd_a_data), .rd_b_data(rd_b_data),
		.rd_d_data(rd_d_data), .wr_req(wr_req), .pc_in(pc_in),
		.ret_addr(ret_addr), .intr_take(ev[2]), .trap_take(ev[1]),
		.excp_take(ev[3]), .link_take(ev[0]), .mfs_en(mfs_en),
		.mfs_sel(mfs_sel), .mfs_dst(mfs_dst), .mts_en(mts_en),
		.mts_sel(mts_sel), .mts_src(mts_src), .spr_hw_upd(hw_upd),
		.msr_hw(hw_msr), .ear_hw(hw_ear), .esr_hw(hw_esr), .fsr_hw(hw_fsr),
		.spr_rd_data(spr_rd_data), .spr_rd_valid(spr_rd_valid));
	crf_pipe_model u_pipe (.sys_clk(sys_clk), .pc_in(pc_in),
		.ret_addr(ret_addr), .ev(ev));
	// Same stimulus with exception support built in
	crf_regfile #(.USE_HW_EXC(1'b1)) u_dut_hx (.sys_clk(sys_clk),
		.rstn(rstn), .rd_a_idx(rd_a_idx), .rd_b_idx(rd_b_idx),
		.rd_d_idx(rd_d_idx), .rd_a_data(hx_a), .rd_b_data(),
		.rd_d_data(), .wr_req(wr_req), .pc_in(pc_in),
		.ret_addr(ret_addr), .intr_take(ev[2]), .trap_take(ev[1]),
		.excp_take(ev[3]), .link_take(ev[0]), .mfs_en(mfs_en),
		.mfs_sel(mfs_sel), .mfs_dst(mfs_dst), .mts_en(mts_en),
		.mts_sel(mts_sel), .mts_src(mts_src), .spr_hw_upd(hw_upd),
		.msr_hw(hw_msr), .ear_hw(hw_ear), .esr_hw(hw_esr),
		.fsr_hw(hw_fsr), .spr_rd_data(), .spr_rd_valid());
	// ============================================================
	// Helpers
	task automatic chk(input string nm, input logic [31:0] s, e);
		n_checks++;
		if (s !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic chk_reg(input logic [4:0] i, input logic [31:0] e);
		sync;
		rd_a_idx = i;
		rd_b_idx = i;
		rd_d_idx = 5'h1F - i;
		#1;
		chk("rd_a", rd_a_data, e);
		chk("rd_b", rd_b_data, e);
		sync;
		rd_d_idx = i;
		#1;
		chk("rd_d", rd_d_data, e);
	endtask
	task automatic sync;
		@(posedge sys_clk);
		#1;
	endtask
	// Lets one edge take the request, then drops all pulses
	task automatic tick;
		sync;
		wr_req.en = 1'b0;
		mfs_en = 1'b0;
		mts_en = 1'b0;
		hw_upd = 1'b0;
		u_pipe.set_ev(4'h0);
	endtask
	task automatic print_verdict;
		if (errors == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// ============================================================
	// Scenarios
	task automatic t_reset;
		for (int i = 0; i < 32; i++) chk_reg(5'(i), 32'h0);
		foreach (sels[j]) begin
			mfs_sel = sels[j];
			#1 chk("spr", spr_rd_data, 32'h0);
		end
		sync;
		mfs_sel = CRF_SPR_PC;
		#1 chk("pc", spr_rd_data, pc_in);
	endtask
	task automatic t_write;
		for (int i = 0; i < 32; i++) begin
			sync;
			wr_req = '{1'b1, 5'(i), 32'hA500_0000 | i};
			tick;
		end
		chk_reg(5'h00, 32'h0);
		for (int i = 1; i < 32; i++) chk_reg(5'(i), 32'hA500_0000 | i);
	endtask
	task automatic t_events;
		logic [31:0] x;
		sync;
		wr_req = '{1'b1, CRF_IDX_INTR, 32'h1111_1111};
		u_pipe.set_ev(4'h4);
		x = ret_addr;
		tick;
		chk_reg(CRF_IDX_INTR, x);
		sync;
		u_pipe.set_ev(4'h2);
		x = ret_addr;
		tick;
		chk_reg(CRF_IDX_TRAP, x);
		sync;
		wr_req = '{1'b1, 5'h05, 32'h2222_2222};
		u_pipe.set_ev(4'h1);
		x = pc_in;
		tick;
		chk_reg(CRF_IDX_LINK, x);
		chk_reg(5'h05, 32'hA500_0005);
		sync;
		u_pipe.set_ev(4'h8);
		x = ret_addr;
		tick;
		chk_reg(CRF_IDX_EXCP, 32'hA500_0011);
		chk("hx_r17", hx_a, x);
	endtask
	task automatic t_spr;
		foreach (sels[j]) begin
			sync;
			mts_en = 1'b1;
			mts_sel = sels[j];
			mts_src = 5'(j + 1);
			tick;
			mfs_sel = sels[j];
			#1 chk("mts", spr_rd_data, 32'hA500_0001 + j);
			chk("valid", {31'h0, spr_rd_valid}, 32'h1);
		end
		chk_reg(5'h03, 32'hA500_0003);
		sync;
		mfs_en = 1'b1;
		mfs_sel = CRF_SPR_EAR;
		mfs_dst = 5'h14;
		wr_req = '{1'b1, 5'h14, 32'h3333_3333};
		tick;
		chk_reg(5'h14, 32'hA500_0002);
		sync;
		mfs_en = 1'b1;
		mfs_sel = 3'h2;
		mfs_dst = 5'h15;
		tick;
		chk_reg(5'h15, 32'hA500_0015);
		chk("valid", {31'h0, spr_rd_valid}, 32'h0);
		sync;
		hw_upd = 1'b1;
		hw_msr = 32'h5A5A_0001;
		hw_ear = 32'h5A5A_0002;
		hw_esr = 32'h5A5A_0003;
		hw_fsr = 32'h5A5A_0004;
		// Move-to in the same cycle must lose to the hardware update
		mts_en = 1'b1;
		mts_sel = CRF_SPR_MSR;
		tick;
		foreach (sels[j]) begin
			mfs_sel = sels[j];
			#1 chk("hw", spr_rd_data, 32'h5A5A_0001 + j);
			sync;
		end
	endtask
	task automatic t_rst_mid;
		sync;
		rstn = 1'b0;
		sync;
		sync;
		rstn = 1'b1;
		t_reset;
	endtask
	// ============================================================
	// Clock, watchdog, main sequence
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	initial begin
		#100000;
		errors++;
		print_verdict;
	end
	initial begin
		{rstn, mfs_en, mts_en, hw_upd, wr_req} = '0;
		{hw_msr, hw_ear, hw_esr, hw_fsr} = '0;
		{rd_a_idx, rd_b_idx, rd_d_idx, mfs_dst, mts_src} = '0;
		{mfs_sel, mts_sel} = '0;
		repeat (10) @(posedge sys_clk);
		#1 rstn = 1'b1;
		t_reset;
		t_write;
		t_events;
		t_spr;
		t_rst_mid;
		print_verdict;
	end
endmodule // tb_top
`default_nettype wire
